// ---- src/supervisor_consts.vh ----
// Purpose: constants for the supply supervisor and watchdog
// Assumes: counts are in ticks of the selected timing source
// Notes:   internal tick rate is a divider of clk
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH

// External clock periods, in timing ticks
`define EXT_FIRST_TICKS   16'd20480
`define EXT_OTHER_TICKS   16'd5120
`define EXT_RESET_TICKS   16'd641
// Internal oscillator periods, in internal ticks of 1 ms
`define INT_TICK_NS       1000000
`define INT_FIRST_MS      16'd2700
`define INT_SHORT_MS      16'd170
`define INT_RESET_MS      16'd85
// Least reset stretch after power-up
`define RESET_MIN_MS      16'd50
`define CLK_PERIOD_NS     10
`define INT_TICK_CYCLES   (`INT_TICK_NS / `CLK_PERIOD_NS)
// Open-strobe detection: cycles without a defined level
`define FLOAT_CYCLES      16'd255
`define TICK_DIV_W        17
`define CNT_W             16

`endif

// ---- src/sync3.v ----
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d is asynchronous to clk
// Notes:   q changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module sync3 #(
    parameter RST_VAL = 1'b1
) (
    input  wire clk,
    input  wire rst,
    input  wire d,
    output reg  q
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    always @(posedge clk) begin
        if (rst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            q     <= RST_VAL;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                q <= s3_ff;
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/supply_supervisor_watchdog.v ----
// Purpose: supply supervisor with reset stretch and strobe watchdog
// Assumes: comparators are outside; their results arrive as pins
// Notes:   strobe_open flags an undriven strobe pin (pad sense)
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_consts.vh"
module supply_supervisor_watchdog (
    input  wire clk,
    input  wire rst,
    input  wire supply_trip_std,
    input  wire supply_trip_tight,
    input  wire tight_option,
    input  wire watchdog_kick_n,
    input  wire strobe_open,
    input  wire timing_source_in,
    input  wire timing_source_select,
    output reg  supply_below_threshold_n,
    output reg  power_fail_out,
    output reg  reset_out,
    output reg  reset_out_n,
    output reg  watchdog_expired_n
);
    localparam ST_RESET = 2'd0;
    localparam ST_RUN   = 2'd1;
    // Bite state lasts one cycle to mark a watchdog-forced reset
    localparam ST_BITE  = 2'd2;

    wire trip_std_s;
    wire trip_tight_s;
    wire kick_s;
    wire open_s;
    wire osc_in_s;
    wire osc_sel_s;

    // Trip pins start as supply low, so outputs stay safe until seen
    sync3 #(.RST_VAL(1'b1)) u_trip_std (
        .clk (clk),
        .rst (rst),
        .d   (supply_trip_std),
        .q   (trip_std_s)
    );

    sync3 #(.RST_VAL(1'b1)) u_trip_tight (
        .clk (clk),
        .rst (rst),
        .d   (supply_trip_tight),
        .q   (trip_tight_s)
    );

    sync3 #(.RST_VAL(1'b1)) u_kick (
        .clk (clk),
        .rst (rst),
        .d   (watchdog_kick_n),
        .q   (kick_s)
    );

    sync3 #(.RST_VAL(1'b1)) u_open (
        .clk (clk),
        .rst (rst),
        .d   (strobe_open),
        .q   (open_s)
    );

    sync3 #(.RST_VAL(1'b0)) u_osc_in (
        .clk (clk),
        .rst (rst),
        .d   (timing_source_in),
        .q   (osc_in_s)
    );

    sync3 #(.RST_VAL(1'b1)) u_osc_sel (
        .clk (clk),
        .rst (rst),
        .d   (timing_source_select),
        .q   (osc_sel_s)
    );

    reg [`TICK_DIV_W-1:0] div_ff;
    reg                   int_tick_ff;
    reg                   osc_prev_ff;
    reg                   kick_prev_ff;
    reg [1:0]             state_ff;
    reg [`CNT_W-1:0]      cnt_ff;
    // Long first timeout until the first kick or bite
    reg                   first_ff;
    reg                   power_up_ff;

    // Trip selects by tolerance option; both share downstream logic
    wire supply_low = tight_option ? trip_tight_s : trip_std_s;

    // Internal oscillator: one-cycle enable every 1 ms
    // Divider width covers one tick of clk cycles
    always @(posedge clk) begin
        if (rst) begin
            div_ff      <= {`TICK_DIV_W{1'b0}};
            int_tick_ff <= 1'b0;
        end else if (div_ff == `INT_TICK_CYCLES - 1) begin
            div_ff      <= {`TICK_DIV_W{1'b0}};
            int_tick_ff <= 1'b1;
        end else begin
            div_ff      <= div_ff + 1'b1;
            int_tick_ff <= 1'b0;
        end
    end

    // Edge history for the external source
    always @(posedge clk) begin
        if (rst) begin
            osc_prev_ff <= 1'b0;
        end else begin
            osc_prev_ff <= osc_in_s;
        end
    end

    // Idle-high start so leaving reset never looks like a kick
    always @(posedge clk) begin
        if (rst) begin
            kick_prev_ff <= 1'b1;
        end else begin
            kick_prev_ff <= kick_s;
        end
    end

    // Select low: external clock rising edges; high: internal ticks
    wire ext_mode = ~osc_sel_s;
    wire tick     = ext_mode ? (osc_in_s & ~osc_prev_ff) : int_tick_ff;
    wire kick     = kick_prev_ff & ~kick_s & ~open_s;

    // Period lengths for the selected timing source
    reg [`CNT_W-1:0] reset_len;
    reg [`CNT_W-1:0] wd_len;
    always @* begin
        if (ext_mode) begin
            reset_len = `EXT_RESET_TICKS;
        end else begin
            // Internal stretch must also cover the power-up minimum
            reset_len = `INT_RESET_MS;
        end
    end

    // Long internal timeout while the source pin is held high
    always @* begin
        if (ext_mode) begin
            wd_len = first_ff ? `EXT_FIRST_TICKS : `EXT_OTHER_TICKS;
        end else if (first_ff || osc_in_s) begin
            wd_len = `INT_FIRST_MS;
        end else begin
            wd_len = `INT_SHORT_MS;
        end
    end

    // Next-state terms, registered below
    reg [1:0]        nxt_state;
    reg [`CNT_W-1:0] nxt_cnt;
    reg              nxt_first;
    reg              nxt_wds_n;
    reg              nxt_power_up;
    always @* begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_first    = first_ff;
        nxt_wds_n    = watchdog_expired_n;
        nxt_power_up = power_up_ff;
        // Release first; low supply further down overrides it
        if (kick || open_s) begin
            nxt_wds_n = 1'b1;
        end
        case (state_ff)
            ST_RESET: begin
                if (supply_low) begin
                    nxt_cnt      = {`CNT_W{1'b0}};
                    nxt_power_up = 1'b1;
                    nxt_first    = 1'b1;
                end else if (tick) begin
                    if (cnt_ff >= reset_len - 1'b1 &&
                        (!power_up_ff || ext_mode || cnt_ff >= `RESET_MIN_MS - 1'b1)) begin
                        nxt_state    = ST_RUN;
                        nxt_cnt      = {`CNT_W{1'b0}};
                        nxt_power_up = 1'b0;
                    end else begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                // Supply loss outranks kicks and ticks
                if (supply_low) begin
                    nxt_state = ST_RESET;
                    nxt_cnt   = {`CNT_W{1'b0}};
                    nxt_first = 1'b1;
                end else if (open_s) begin
                    nxt_cnt = {`CNT_W{1'b0}};
                end else if (kick) begin
                    nxt_cnt   = {`CNT_W{1'b0}};
                    nxt_first = 1'b0;
                end else if (tick) begin
                    if (cnt_ff >= wd_len - 1'b1) begin
                        nxt_state = ST_BITE;
                        nxt_cnt   = {`CNT_W{1'b0}};
                        nxt_wds_n = 1'b0;
                    end else begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
            end
            ST_BITE: begin
                // Watchdog-forced reset; later periods use the short timeout
                // Count was already cleared on the bite tick
                nxt_state = ST_RESET;
                nxt_first = 1'b0;
            end
            default: begin
                nxt_state = ST_RESET;
                nxt_cnt   = {`CNT_W{1'b0}};
            end
        endcase
        if (supply_low) begin
            nxt_wds_n = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_RESET;
            cnt_ff   <= {`CNT_W{1'b0}};
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Both flags start set: a fresh start gets the long first period
    always @(posedge clk) begin
        if (rst) begin
            first_ff    <= 1'b1;
            power_up_ff <= 1'b1;
        end else begin
            first_ff    <= nxt_first;
            power_up_ff <= nxt_power_up;
        end
    end

    // Reset outputs follow the next state so they move with it
    wire nxt_reset = (nxt_state != ST_RUN);

    // Threshold flag follows supply with no stretch
    always @(posedge clk) begin
        if (rst) begin
            supply_below_threshold_n <= 1'b0;
            power_fail_out           <= 1'b1;
        end else begin
            supply_below_threshold_n <= ~supply_low;
            power_fail_out           <= supply_low;
        end
    end

    // Both polarities from one term, so they can never disagree
    always @(posedge clk) begin
        if (rst) begin
            reset_out   <= 1'b1;
            reset_out_n <= 1'b0;
        end else begin
            reset_out   <= nxt_reset;
            reset_out_n <= ~nxt_reset;
        end
    end

    // Status is latched; only a kick, open strobe or reset releases it
    always @(posedge clk) begin
        if (rst) begin
            watchdog_expired_n <= 1'b1;
        end else begin
            watchdog_expired_n <= nxt_wds_n;
        end
    end
endmodule
`default_nettype wire

// ---- dv/supervisor_assertions.sv ----
// Purpose: port-level checks for the supply supervisor
// Assumes: external timing clock whenever the select pin is low
// Notes:   tick counter clears on reset edges and kicks
`timescale 1ns/100ps
`default_nettype none
module supervisor_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_trip_std,
    input wire logic supply_trip_tight,
    input wire logic tight_option,
    input wire logic watchdog_kick_n,
    input wire logic strobe_open,
    input wire logic timing_source_in,
    input wire logic timing_source_select,
    input wire logic supply_below_threshold_n,
    input wire logic power_fail_out,
    input wire logic reset_out,
    input wire logic reset_out_n,
    input wire logic watchdog_expired_n
);
    logic [15:0] tk_ff;
    logic        src_ff;
    logic        kick_ff;
    logic        rout_ff;
    // Ticks only count while supply is good, as the device ignores them otherwise
    always_ff @(posedge clk) begin
        src_ff  <= timing_source_in;
        kick_ff <= watchdog_kick_n;
        rout_ff <= reset_out;
        if (rst || rout_ff != reset_out || (kick_ff && !watchdog_kick_n) ||
            !supply_below_threshold_n)
            tk_ff <= 16'h0;
        else if (timing_source_in && !src_ff && !timing_source_select)
            tk_ff <= tk_ff + 16'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    pair_comp_a: assert property (reset_out_n == !reset_out)
        else $error("reset pair differs");
    low_supply_a: assert property ((!tight_option && supply_trip_std)[*8] |->
        !supply_below_threshold_n && power_fail_out && reset_out && !watchdog_expired_n)
        else $error("low supply not flagged");
    tight_trip_a: assert property ((tight_option && supply_trip_tight)[*6] |->
        !supply_below_threshold_n && reset_out) else $error("tight trip missed");
    flag_rise_a: assert property ((!tight_option && !supply_trip_std)[*7] |->
        supply_below_threshold_n) else $error("flag not released");
    stretch_len_a: assert property ($fell(reset_out) |->
        tk_ff >= 16'd630 && tk_ff <= 16'd650) else $error("reset length wrong");
    bite_time_a: assert property ($fell(watchdog_expired_n) && supply_below_threshold_n |->
        tk_ff >= 16'd5100 ##[0:2] reset_out) else $error("early or resetless bite");
    kick_clear_a: assert property ($fell(watchdog_kick_n) && !reset_out && !strobe_open
        && supply_below_threshold_n |-> ##[1:8] watchdog_expired_n) else $error("kick kept status");
    open_clear_a: assert property ((strobe_open && supply_below_threshold_n)[*6] |->
        watchdog_expired_n) else $error("open strobe kept status");
endmodule
`default_nettype wire

// ---- dv/kick_model.sv ----
// Purpose: processor side, drives the watchdog strobe
// Assumes: one-cycle kick_req pulses from the bench
// Notes:   strobe idles high between kicks
`timescale 1ns/100ps
`default_nettype none
module kick_model (
    input  wire logic clk,
    input  wire logic kick_req,
    output var  logic watchdog_kick_n
);
    int hold_ff = 0;
    initial watchdog_kick_n = 1'b1;
    // Four clocks low and high, so the input filter sees every edge
    always @(posedge clk) begin
        if (kick_req && hold_ff == 0)
            hold_ff <= 8;
        else if (hold_ff != 0)
            hold_ff <= hold_ff - 1;
        watchdog_kick_n <= !(hold_ff > 4);
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: directed bench for the supply supervisor
// Assumes: external timing clock of six clk periods
// Notes:   full-length counts, about 88k clocks
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic supply_trip_std = 1'b1;
    logic supply_trip_tight = 1'b1;
    logic tight_option = 1'b0;
    logic strobe_open = 1'b0;
    logic timing_source_in = 1'b0;
    logic timing_source_select = 1'b0;
    logic kick_req = 1'b0;
    wire  watchdog_kick_n, supply_below_threshold_n, power_fail_out;
    wire  reset_out, reset_out_n, watchdog_expired_n;
    int   n_errors = 0;
    int   n_tests = 0;
    supply_supervisor_watchdog dut (.*);
    kick_model cpu (.clk(clk), .kick_req(kick_req), .watchdog_kick_n(watchdog_kick_n));
    initial forever #5 clk = ~clk;
    initial begin
        #7;
        forever #30 timing_source_in = ~timing_source_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge timing_source_in);
        cyc(1);
    endtask
    task automatic kick;
        kick_req = 1'b1;
        cyc(1);
        kick_req = 1'b0;
    endtask
    task automatic chk(input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic power_up;
        cyc(8);
        chk(1'b0, supply_below_threshold_n);
        chk(1'b1, power_fail_out);
        chk(1'b0, reset_out_n);
        chk(1'b0, watchdog_expired_n);
        supply_trip_std = 1'b0;
        cyc(7);
        chk(1'b1, supply_below_threshold_n);
        ticks(600);
        chk(1'b1, reset_out);
        supply_trip_tight = 1'b0;
        ticks(60);
        chk(1'b0, reset_out);
        chk(1'b1, reset_out_n);
    endtask
    task automatic kick_restart;
        kick;
        ticks(1000);
        kick;
        ticks(4500);
        chk(1'b1, watchdog_expired_n);
        ticks(600);
        chk(1'b1, watchdog_expired_n);
        ticks(40);
        chk(1'b0, watchdog_expired_n);
        chk(1'b1, reset_out);
    endtask
    task automatic open_release;
        ticks(100);
        strobe_open = 1'b1;
        cyc(8);
        chk(1'b1, watchdog_expired_n);
        strobe_open = 1'b0;
        ticks(480);
        chk(1'b1, reset_out);
        ticks(60);
        chk(1'b0, reset_out);
    endtask
    task automatic late_bite;
        ticks(5060);
        chk(1'b1, watchdog_expired_n);
        ticks(60);
        chk(1'b0, watchdog_expired_n);
        ticks(660);
        chk(1'b0, watchdog_expired_n);
        kick;
        cyc(12);
        chk(1'b1, watchdog_expired_n);
    endtask
    task automatic supply_drop;
        supply_trip_std = 1'b1;
        supply_trip_tight = 1'b1;
        cyc(8);
        chk(1'b1, reset_out);
        chk(1'b0, watchdog_expired_n);
    endtask
    task automatic int_hold;
        supply_trip_std = 1'b0;
        timing_source_select = 1'b1;
        ticks(700);
        chk(1'b1, reset_out);
        chk(1'b1, supply_below_threshold_n);
        timing_source_select = 1'b0;
        ticks(660);
        chk(1'b0, reset_out);
    endtask
    task automatic tight_trip;
        rst = 1'b1;
        tight_option = 1'b1;
        supply_trip_std = 1'b0;
        cyc(2);
        rst = 1'b0;
        cyc(8);
        chk(1'b0, supply_below_threshold_n);
        supply_trip_tight = 1'b0;
        cyc(7);
        chk(1'b1, supply_below_threshold_n);
        chk(1'b0, power_fail_out);
    endtask
    task automatic close_out;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        cyc(16);
        rst = 1'b0;
        power_up;
        kick_restart;
        open_release;
        late_bite;
        supply_drop;
        int_hold;
        tight_trip;
        close_out;
    end
    initial begin
        #990_000;
        n_errors++;
        close_out;
    end
endmodule
bind supply_supervisor_watchdog supervisor_assertions chk (.*);
`default_nettype wire
